// >>> rtl/spirc_regs.svh
`ifndef SPIRC_REGS_SVH
`define SPIRC_REGS_SVH

// Frame layout, MSB first
`define SPIRC_ADDR_W 7
`define SPIRC_DATA_W 8
`define SPIRC_NREGS 128
`define SPIRC_BYTE_BITS 4'h8
`define SPIRC_DIR_WRITE 1'h0
`define SPIRC_DIR_READ 1'h1
`define SPIRC_REG_RESET 8'h00
// Flip-flop stages in each synchronizer that brings a link signal into the core clock
`define SPIRC_SYNC_STAGES 2

`endif

// >>> rtl/spirc_pkg.sv
package spirc_pkg;
  typedef enum logic [1:0] {spirc_cmd, spirc_wdata, spirc_rdata, spirc_done} spirc_phase_t;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } spirc_wr_t;
  typedef struct packed {
    logic [6:0] addr;
  } spirc_rd_t;
endpackage

// >>> rtl/spirc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module spirc_sync (
  input wire logic clk,
  input wire logic nrst,
  input wire logic d,
  output logic q
);
  logic meta;
  // Only the second stage is read outside this module
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta <= 1'h0;
      q <= 1'h0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // spirc_sync
`default_nettype wire

// >>> rtl/spirc_link.sv
`timescale 1ns/1ps
`default_nettype none
`include "spirc_regs.svh"
module spirc_link (
  input wire logic sclk,
  input wire logic slave_select_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  output logic [6:0] rd_addr,
  input wire logic [7:0] rd_data,
  output spirc_pkg::spirc_wr_t wr_word,
  output logic wr_toggle
);
  import spirc_pkg::*;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic [7:0] tx;
  logic dir;
  logic tog_q = 1'h0; // No reset reaches the link clock; power-up value only
  spirc_phase_t phase;

  // Sample on falling edge (CPOL 0, CPHA 1); select high holds the frame logic in reset
  always_ff @(negedge sclk or posedge slave_select_n) begin
    if (slave_select_n) begin
      cnt <= 4'h0;
      sh <= 8'h00;
      dir <= 1'h0;
      phase <= spirc_cmd;
      rd_addr <= 7'h00;
    end else begin
      sh <= {sh[6:0], mosi};
      if (cnt == `SPIRC_BYTE_BITS - 4'h1) begin
        cnt <= 4'h0;
        unique case (phase)
          spirc_cmd: begin
            rd_addr <= sh[6:0];
            dir <= mosi;
            phase <= (mosi == `SPIRC_DIR_READ) ? spirc_rdata : spirc_wdata;
          end
          default: phase <= spirc_done;
        endcase
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end

  // Write word is stable while its toggle crosses; it toggles only after a full data byte
  always_ff @(negedge sclk) begin
    if (!slave_select_n && phase == spirc_wdata && cnt == `SPIRC_BYTE_BITS - 4'h1) begin
      wr_word <= '{addr: rd_addr, data: {sh[6:0], mosi}};
      tog_q <= ~tog_q;
    end
  end

  assign wr_toggle = tog_q;

  // Launch on rising edge; first bit of the read byte uses live register data
  always_ff @(posedge sclk or posedge slave_select_n) begin
    if (slave_select_n) begin
      tx <= 8'h00;
    end else if (phase == spirc_rdata && cnt == 4'h0) begin
      tx <= rd_data;
    end else begin
      tx <= {tx[6:0], 1'h0};
    end
  end

  // Bit appears from the first clock edge of each read-byte bit; no clock made here
  always_comb begin
    miso = tx[7];
    miso_oe = !slave_select_n;
  end

  a_read_msb: assert property (@(negedge sclk) disable iff (slave_select_n)
    (phase == spirc_rdata && cnt == 4'h0) |-> miso == rd_data[7])
    else $error("read byte msb wrong");
  a_cmd_quiet: assert property (@(negedge sclk) disable iff (slave_select_n)
    (phase == spirc_cmd) |-> !miso)
    else $error("miso not low during command");
endmodule // spirc_link
`default_nettype wire

// >>> rtl/spirc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "spirc_regs.svh"
// What this block does
// - Serial clock idles low; data sampled on falling edges.
// - Host and device both launch data on the first clock edge.
// - Only the host clocks and starts transfers; device never paces.
// - One MISO bit leaves for every MOSI bit received.
// - First byte after select falls is a command; data byte only on write.
// - Decoding restarts only at a falling edge of select.
// - Command holds 7-bit address then a direction bit.
// - Direction 0 write stores the second byte in the addressed register.
// - Direction 1 read sends the register byte in the second byte.
module spirc_top #(
  parameter int NREGS = `SPIRC_NREGS
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic spi_select,
  input wire logic sclk,
  input wire logic slave_select_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  output logic [NREGS*8-1:0] regs_out
);
  import spirc_pkg::*;
  logic [7:0] regs [NREGS];
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  spirc_wr_t wr_word;
  logic wr_toggle;
  logic tog_s;
  logic tog_d;
  logic sel_s;
  logic link_miso;
  logic link_oe;

  // ----------------------------------------
  // Link domain
  // ----------------------------------------
  spirc_link u_link (
    .sclk(sclk),
    .slave_select_n(slave_select_n),
    .mosi(mosi),
    .miso(link_miso),
    .miso_oe(link_oe),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .wr_word(wr_word),
    .wr_toggle(wr_toggle)
  );

  // Read path is a direct mux: host clock is far slower than setup of register outputs
  assign rd_data = regs[rd_addr];

  // ----------------------------------------
  // Crossing and register file
  // ----------------------------------------
  spirc_sync u_tog (
    .clk(clk),
    .nrst(nrst),
    .d(wr_toggle),
    .q(tog_s)
  );
  spirc_sync u_sel (
    .clk(clk),
    .nrst(nrst),
    .d(spi_select),
    .q(sel_s)
  );

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tog_d <= 1'h0;
    end else begin
      tog_d <= tog_s;
    end
  end

  // Word stays stable for a whole byte time, far beyond the sync delay
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < NREGS; i++) begin
        regs[i] <= `SPIRC_REG_RESET;
      end
    end else if (tog_s != tog_d && sel_s) begin
      regs[wr_word.addr] <= wr_word.data;
    end
  end

  always_comb begin
    for (int i = 0; i < NREGS; i++) begin
      regs_out[i*8 +: 8] = regs[i];
    end
  end

  // Only the miso enable is forced low when the other protocol is selected; miso itself is not gated
  assign miso = link_miso;
  assign miso_oe = link_oe && sel_s;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_write_lands: assert property (@(posedge clk) disable iff (!nrst)
    (tog_s != tog_d && sel_s) |=> regs[$past(wr_word.addr)] == $past(wr_word.data))
    else $error("write not stored");
  a_regs_hold: assert property (@(posedge clk) disable iff (!nrst)
    (tog_s == tog_d) |=> regs[0] == $past(regs[0]))
    else $error("register changed without write");
  a_oe_select: assert property (@(posedge clk) disable iff (!nrst)
    slave_select_n |-> !miso_oe)
    else $error("miso driven while deselected");
  a_sel_gate: assert property (@(posedge clk) disable iff (!nrst)
    !sel_s |-> !miso_oe)
    else $error("miso driven in other mode");
  c_write: cover property (@(posedge clk) disable iff (!nrst) tog_s != tog_d);
  c_select: cover property (@(posedge clk) disable iff (!nrst) $fell(slave_select_n));
  c_drive: cover property (@(posedge clk) disable iff (!nrst) miso_oe);
endmodule // spirc_top
`default_nettype wire

// >>> test/spirc_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------
// Host model
// ----------
module spirc_host (
  output logic sclk,
  output logic slave_select_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sclk = 1'h0;
    slave_select_n = 1'h1;
    mosi = 1'h0;
  end
  // Only the host clocks and frames; sclk stands low outside frames
  task automatic xfer(input logic [6:0] addr, input logic dir, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {addr, dir, wd}; // Caller passes full bytes
    rd = 8'h00;
    slave_select_n = 1'h0;
    #40;
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'h1;
      mosi = sh[i]; // Launch on the first edge
      #32;
      sclk = 1'h0;
      if (i < 8) rd[i] = miso; // Sampled on falling edge
      #32;
    end
    slave_select_n = 1'h1;
    mosi = ~mosi; // Released line must not keep its last bit
    #40;
  endtask
endmodule // spirc_host
`default_nettype wire

// >>> test/spirc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module spirc_top_test;
  logic clk, nrst, spi_select, sclk, slave_select_n, mosi, miso, miso_oe;
  logic [1023:0] regs_out;
  logic [7:0] rd;
  int fail_count = 0;
  int total_checks = 0;
  spirc_top spirc_top_i (.clk(clk), .nrst(nrst), .spi_select(spi_select), .sclk(sclk),
    .slave_select_n(slave_select_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .regs_out(regs_out));
  spirc_host spirc_host_i (.sclk(sclk), .slave_select_n(slave_select_n), .mosi(mosi), .miso(miso));
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ---------
  // Scenarios
  // ---------
  task automatic t_write_read(input logic [6:0] a, input logic [7:0] d);
    spirc_host_i.xfer(a, 1'h0, d, rd);
    repeat (6) @(posedge clk);
    check("reg", regs_out[a*8 +: 8], d);
    check("wr_miso", rd, 8'h00);
    spirc_host_i.xfer(a, 1'h1, ~d, rd);
    check("rd", rd, d);
    repeat (6) @(posedge clk);
    check("rd_nowrite", regs_out[a*8 +: 8], d);
    check("oe_idle", {7'h00, miso_oe}, 8'h00);
  endtask
  task automatic t_disabled;
    @(posedge clk);
    spi_select <= 1'h0;
    repeat (4) @(posedge clk);
    spirc_host_i.xfer(7'h09, 1'h0, 8'hff, rd);
    repeat (6) @(posedge clk);
    check("ignored", regs_out[9*8 +: 8], 8'h00);
    spi_select <= 1'h1;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    nrst = 1'h0;
    spi_select = 1'h1;
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    repeat (2) @(posedge clk);
    check("rst0", regs_out[7:0], 8'h00);
    check("rst127", regs_out[1023:1016], 8'h00);
    #7;
    t_write_read(7'h00, 8'ha5);
    t_write_read(7'h7f, 8'h3c);
    t_write_read(7'h05, 8'h81);
    t_disabled();
    stop_test();
  end
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end
endmodule // spirc_top_test
`default_nettype wire
